// file: include/asp_pkg.sv
// Constants and types shared by both ends of the serial converter port
// Function
// [RULE_01] Frame runs from select fall to rise
// [RULE_02] Controller gives rising edges in multiples of sixteen
// [RULE_03] Output driven only while select low
// [RULE_04] Serial clock ignored while select high
// [RULE_05] Three cycles track, thirteen convert
// [RULE_06] Falls one to four zeros, then result
// [RULE_07] Continuous frames restart track every sixteen
// [RULE_08] Select fall, clock high: track next fall
// [RULE_09] Select fall, clock low: counts as fall
// [RULE_10] Simultaneous falls also enter tracking
// [RULE_11] First eight rises load the control word
// [RULE_12] Captured channel applies to next conversion
// [RULE_13] Control bits 7,6,2,1,0 ignored
// [RULE_14] Bits 5 to 3 select channel
// [RULE_15] First result arbitrary; run one dummy
// [RULE_16] Any idle time between frames allowed
// [RULE_17] Result is straight binary
// [RULE_18] Powered while select low only
// [RULE_19] Powered down between fall sixteen and next
// [RULE_20] Controller shifts control word MSB first
// [RULE_21] Controller samples output after falling edges
package asp_pkg;
	localparam int CLK_PERIOD_NS = 10;
	localparam int SCLK_HALF_NS  = 40;
	localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	localparam int CONV_CYCLES   = 16;
	localparam int HOLD_FALL     = 4;
	localparam int LEAD_ZEROS    = 4;
	localparam int RESULT_W      = 12;
	localparam int CTRL_W        = 8;
	localparam int CTRL_RISES    = 8;
	localparam int CHAN_W        = 3;
	localparam int CHAN_MSB      = 5;
	localparam int CHAN_LSB      = 3;
	localparam logic [CHAN_W-1:0] CHAN_RESET = 3'h0;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 8'h00;

	localparam int ADDR_W        = 4;
	localparam int DATA_W        = 32;
	localparam logic [ADDR_W-1:0] REG_CMD    = 4'h0;
	localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;
	localparam logic [ADDR_W-1:0] REG_RESULT = 4'h8;
	localparam int CMD_CHAN_LSB  = 0;
	localparam int CMD_CNT_LSB   = 8;
	localparam int CNT_W         = 4;
	localparam int ST_BUSY_BIT   = 0;
	localparam int ST_DONE_BIT   = 1;
	localparam int ST_WORD_BIT   = 2;
	localparam int ST_WCNT_LSB   = 8;
	localparam int WCNT_W        = 8;

	typedef enum {H_IDLE, H_LEAD, H_LOW, H_HIGH, H_TAIL} asp_host_state_type;
endpackage : asp_pkg

// file: include/asp_link_if.sv
// Serial link between converter and controller
`timescale 1ns/1ps
interface asp_link_if;
	logic sel_n;
	logic sclk;
	logic sdi;
	logic sdo;
	logic sdo_oe;
	logic sdo_line;

	// Released line reads high
	assign sdo_line = sdo_oe ? sdo : 1'b1;

	modport dev  (input sel_n, input sclk, input sdi, output sdo, output sdo_oe);
	modport host (output sel_n, output sclk, output sdi, input sdo_line);
endinterface : asp_link_if

// file: hw/asp_device.sv
// Converter end: frame, track/hold sequencing, control word, result shift
`timescale 1ns/1ps
module asp_device
	import asp_pkg::*;
#(
	parameter int RES_W = RESULT_W
) (
	input  wire logic              mclk_i,
	input  wire logic              arst_n_i,
	input  wire logic              ce_i,
	asp_link_if.dev                link,
	input  wire logic [RES_W-1:0]  sample_i,
	output logic      [CHAN_W-1:0] chan_o,
	output logic                   track_o,
	output logic                   powered_o,
	output logic      [CTRL_W-1:0] ctrl_o
);
	logic              sel_n_prev_ff;
	logic              sclk_prev_ff;
	logic [4:0]        fall_cnt_ff;
	logic [3:0]        rise_cnt_ff;
	logic [CTRL_W-1:0] shift_ff;
	logic [CTRL_W-1:0] ctrl_ff;
	logic [CHAN_W-1:0] pend_chan_ff;
	logic [CHAN_W-1:0] chan_ff;
	logic [RES_W-1:0]  sample_ff;
	logic              sdo_ff;
	logic              track_ff;
	logic              power_ff;

	////////////////////////////////////////////////////////////////////////////
	// Edge decode, gated by select
	wire       sel       = ~link.sel_n;
	wire       start     = sel & sel_n_prev_ff;                         // RULE_01
	wire       sclk_fall = sel & sclk_prev_ff & ~link.sclk;             // RULE_04
	wire       sclk_rise = sel & ~sclk_prev_ff & link.sclk;             // RULE_04
	wire       eff_fall  = start ? ~link.sclk : sclk_fall;              // RULE_08 RULE_09 RULE_10
	wire [4:0] fall_base = start ? 5'h00 : fall_cnt_ff;
	wire [4:0] nxt_fall  = ~eff_fall ? fall_base :
		(fall_base == 5'(CONV_CYCLES)) ? 5'h01 : fall_base + 5'h01;     // RULE_07
	wire [3:0] rise_base = start ? 4'h0 : rise_cnt_ff;
	wire       ctrl_bit  = sclk_rise & (rise_base < 4'(CTRL_RISES));    // RULE_11
	wire       ctrl_last = ctrl_bit & (rise_base == 4'(CTRL_RISES - 1));
	wire [CTRL_W-1:0] nxt_shift = {shift_ff[CTRL_W-2:0], link.sdi};
	wire       new_conv  = eff_fall & (nxt_fall == 5'h01);
	wire       hold_now  = eff_fall & (nxt_fall == 5'(HOLD_FALL));      // RULE_05
	wire [4:0] bit_idx   = 5'(CONV_CYCLES) - nxt_fall;
	wire       nxt_sdo   = (nxt_fall <= 5'(LEAD_ZEROS)) ? 1'b0
		: sample_ff[bit_idx[3:0]];                                      // RULE_06 RULE_17
	wire       nxt_track = sel & (nxt_fall != 5'h00) & (nxt_fall < 5'(HOLD_FALL)); // RULE_05
	wire       nxt_power = sel & (nxt_fall != 5'(CONV_CYCLES));         // RULE_18 RULE_19

	////////////////////////////////////////////////////////////////////////////
	// Sequencing state
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sel_n_prev_ff <= 1'b1;
			sclk_prev_ff  <= 1'b1;
			fall_cnt_ff   <= 5'h00;
			rise_cnt_ff   <= 4'h0;
			track_ff      <= 1'b0;
			power_ff      <= 1'b0;
			sdo_ff        <= 1'b0;
		end else if (ce_i) begin
			sel_n_prev_ff <= link.sel_n;
			sclk_prev_ff  <= link.sclk;
			fall_cnt_ff   <= sel ? nxt_fall : 5'h00;                  // RULE_16
			rise_cnt_ff   <= sclk_rise ? rise_base + 4'h1 : rise_base;
			track_ff      <= nxt_track;
			power_ff      <= nxt_power;
			if (eff_fall) begin
				sdo_ff <= nxt_sdo;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Control word, channel and sample
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			shift_ff     <= CTRL_RESET;
			ctrl_ff      <= CTRL_RESET;
			pend_chan_ff <= CHAN_RESET;
			chan_ff      <= CHAN_RESET;
			sample_ff    <= '0;
		end else if (ce_i) begin
			if (ctrl_bit) begin
				shift_ff <= nxt_shift;
			end
			if (ctrl_last) begin
				ctrl_ff      <= nxt_shift;
				pend_chan_ff <= nxt_shift[CHAN_MSB:CHAN_LSB];             // RULE_13 RULE_14
			end
			if (new_conv) begin
				chan_ff <= pend_chan_ff;                                  // RULE_12
			end
			if (hold_now) begin
				sample_ff <= sample_i;
			end
		end
	end

	assign link.sdo    = sdo_ff;
	assign link.sdo_oe = sel;                                          // RULE_03
	assign chan_o      = chan_ff;
	assign track_o     = track_ff;
	assign powered_o   = power_ff;
	assign ctrl_o      = ctrl_ff;
endmodule : asp_device

// file: hw/asp_host.sv
// Controller end: register port, frame generation, result collection
`timescale 1ns/1ps
module asp_host
	import asp_pkg::*;
#(
	parameter int HALF_CYC = SCLK_HALF_CYC
) (
	input  wire logic              mclk_i,
	input  wire logic              arst_n_i,
	input  wire logic              ce_i,
	asp_link_if.host               link,
	input  wire logic [ADDR_W-1:0] addr_i,
	input  wire logic [DATA_W-1:0] wdata_i,
	input  wire logic              we_i,
	input  wire logic              re_i,
	output logic      [DATA_W-1:0] rdata_o
);
	asp_host_state_type state_ff;
	logic [7:0]        div_ff;
	logic [3:0]        pos_ff;
	logic [CNT_W-1:0]  left_ff;
	logic [CHAN_W-1:0] chan_ff;
	logic              sel_n_ff;
	logic              sclk_ff;
	logic              sdi_ff;
	logic [15:0]       shift_ff;
	logic [15:0]       result_ff;
	logic [WCNT_W-1:0] wcnt_ff;
	logic              done_ff;
	logic              word_ff;
	logic [DATA_W-1:0] rdata_ff;

	////////////////////////////////////////////////////////////////////////////
	// Decode
	wire        idle     = (state_ff == H_IDLE);
	wire        tick     = (div_ff == 8'h00);
	wire        go       = we_i & (addr_i == REG_CMD) & idle;
	wire        st_wr    = we_i & (addr_i == REG_STATUS);
	wire [7:0]  ctrl_wd  = {2'b00, chan_ff, 3'b000};                    // RULE_14
	wire [3:0]  nxt_pos  = pos_ff + 4'h1;
	wire        ctrl_nxt = (nxt_pos < 4'(CTRL_RISES)) ? ctrl_wd[3'(7 - nxt_pos)] : 1'b0; // RULE_20
	wire [15:0] nxt_shift = {shift_ff[14:0], link.sdo_line};             // RULE_21
	wire        word_end = (state_ff == H_LOW) & tick & (pos_ff == 4'hF);
	wire        last     = (pos_ff == 4'hF) & (left_ff == '0);
	wire        frame_end = (state_ff == H_TAIL) & tick;
	wire [DATA_W-1:0] status = DATA_W'({wcnt_ff, 5'h00, word_ff, done_ff, ~idle});
	wire [DATA_W-1:0] rd_mux = (addr_i == REG_STATUS) ? status :
		(addr_i == REG_RESULT) ? DATA_W'(result_ff) : '0;

	////////////////////////////////////////////////////////////////////////////
	// Frame sequencer
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state_ff <= H_IDLE;
			div_ff   <= 8'h00;
			pos_ff   <= 4'h0;
			left_ff  <= '0;
			chan_ff  <= CHAN_RESET;
			sel_n_ff <= 1'b1;
			sclk_ff  <= 1'b1;
			sdi_ff   <= 1'b0;
			shift_ff <= 16'h0000;
		end else if (ce_i) begin
			div_ff <= tick ? 8'(HALF_CYC - 1) : div_ff - 8'h01;
			case (state_ff)
				H_IDLE: begin
					div_ff <= 8'(HALF_CYC - 1);
					if (go) begin
						chan_ff  <= wdata_i[CMD_CHAN_LSB +: CHAN_W];
						left_ff  <= wdata_i[CMD_CNT_LSB +: CNT_W];
						pos_ff   <= 4'h0;
						sel_n_ff <= 1'b0;                                // RULE_08
						sclk_ff  <= 1'b1;
						state_ff <= H_LEAD;
					end
				end
				H_LEAD: if (tick) begin
					sclk_ff  <= 1'b0;
					sdi_ff   <= ctrl_wd[7];                              // RULE_20
					state_ff <= H_LOW;
				end
				H_LOW: if (tick) begin
					sclk_ff  <= 1'b1;
					shift_ff <= nxt_shift;                               // RULE_21
					state_ff <= H_HIGH;
				end
				H_HIGH: if (tick) begin
					if (last) begin
						state_ff <= H_TAIL;                              // RULE_02
					end else begin
						pos_ff   <= nxt_pos;
						sclk_ff  <= 1'b0;
						sdi_ff   <= ctrl_nxt;                            // RULE_11
						state_ff <= H_LOW;
						if (pos_ff == 4'hF) begin
							left_ff <= left_ff - CNT_W'(1);
						end
					end
				end
				H_TAIL: if (tick) begin
					sel_n_ff <= 1'b1;                                    // RULE_16
					state_ff <= H_IDLE;
				end
				default: state_ff <= H_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Results, status and read port
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			result_ff <= 16'h0000;
			wcnt_ff   <= '0;
			done_ff   <= 1'b0;
			word_ff   <= 1'b0;
			rdata_ff  <= '0;
		end else if (ce_i) begin
			if (word_end) begin
				result_ff <= nxt_shift;
				wcnt_ff   <= wcnt_ff + WCNT_W'(1);
			end
			if (go) begin
				wcnt_ff <= '0;
			end
			done_ff  <= frame_end | (done_ff & ~(st_wr & wdata_i[ST_DONE_BIT]));
			word_ff  <= word_end | (word_ff & ~(st_wr & wdata_i[ST_WORD_BIT]));
			rdata_ff <= re_i ? rd_mux : '0;
		end
	end

	assign link.sel_n = sel_n_ff;
	assign link.sclk  = sclk_ff;
	assign link.sdi   = sdi_ff;
	assign rdata_o    = rdata_ff;
endmodule : asp_host

// file: tb/asp_link_asserts.sv
// Protocol checks on the converter serial link
`timescale 1ns/1ps
module asp_link_asserts (
	input wire logic mclk_i,
	input wire logic arst_n_i,
	input wire logic sel_n,
	input wire logic sclk,
	input wire logic sdi,
	input wire logic sdo,
	input wire logic sdo_oe
);
	logic       sclk_q_ff;
	logic [4:0] fcnt_ff;
	logic [7:0] rcnt_ff;
	wire        fall_w   = sclk_q_ff & ~sclk;
	wire  [4:0] fstep_w  = (fcnt_ff == 5'h10) ? 5'h1 : fcnt_ff + 5'h1;
	wire  [4:0] nxt_fcnt = sel_n ? 5'h0 : (fall_w ? fstep_w : fcnt_ff);
	wire  [7:0] nxt_rcnt = sel_n ? 8'h0 : rcnt_ff + {7'h0, ~sclk_q_ff & sclk};
	//////////////////////////////////////////////////////////////////////
	// Fall and rise counters per frame
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sclk_q_ff <= 1'b1;
			fcnt_ff   <= 5'h0;
			rcnt_ff   <= 8'h0;
		end else begin
			sclk_q_ff <= sclk;
			fcnt_ff   <= nxt_fcnt;
			rcnt_ff   <= nxt_rcnt;
		end
	end
	//////////////////////////////////////////////////////////////////////
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!arst_n_i);
	AST_OE_SEL: assert property (sdo_oe == !sel_n)
		else $error("output enable not following select");
	AST_IDLE_CLK: assert property (sel_n && $past(sel_n) |-> sclk)
		else $error("clock moved outside frame");
	AST_FIRST_FALL: assert property ($fell(sel_n) |-> sclk [*4] ##1 !sclk)
		else $error("first clock fall misplaced");
	AST_LEAD_ZERO: assert property ($rose(sclk) && !sel_n && fcnt_ff inside {[1:4]} |-> !sdo)
		else $error("leading bit not zero");
	AST_SDO_HOLD: assert property ($rose(sclk) && !sel_n |=> $stable(sdo) [*3])
		else $error("output changed while clock high");
	AST_SDI_SET: assert property ($rose(sclk) && !sel_n |-> $stable(sdi))
		else $error("input changed at rising clock");
	AST_MULT16: assert property ($rose(sel_n) |-> rcnt_ff[3:0] == 4'h0 && rcnt_ff != 8'h0)
		else $error("frame rises not a multiple of sixteen");
	AST_END_HIGH: assert property ($rose(sel_n) |-> sclk && $past(sclk, 3))
		else $error("frame ended with clock low");
	cover property ($rose(sel_n) && rcnt_ff == 8'h30);
	cover property ($rose(sclk) && fcnt_ff == 5'h5 && sdo);
	cover property ($fell(sel_n));
endmodule : asp_link_asserts

// file: tb/asp_tb.sv
// Self-checking bench for both converter link ends
`timescale 1ns/1ps
module asp_tb
	import asp_pkg::*;
;
	logic                mclk_i;
	logic                arst_n_i;
	logic                ce_i;
	logic [ADDR_W-1:0]   addr_i;
	logic [DATA_W-1:0]   wdata_i;
	logic                we_i;
	logic                re_i;
	logic [DATA_W-1:0]   rdata_o;
	logic [CHAN_W-1:0]   chan_o;
	logic [CTRL_W-1:0]   ctrl_o;
	logic                track_o;
	logic                powered_o;
	logic [RESULT_W-1:0] sample_i;
	int                  err_count;
	int                  n_checks;
	asp_link_if link();
	asp_host u_asp_host (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .ce_i(ce_i), .link(link),
		.addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o));
	asp_device u_asp_device (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .ce_i(ce_i), .link(link),
		.sample_i(sample_i), .chan_o(chan_o), .track_o(track_o), .powered_o(powered_o),
		.ctrl_o(ctrl_o));
	asp_link_asserts u_asp_link_asserts (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
		.sel_n(link.sel_n), .sclk(link.sclk), .sdi(link.sdi), .sdo(link.sdo),
		.sdo_oe(link.sdo_oe));
	//////////////////////////////////////////////////////////////////////
	// Distinct value per channel
	function automatic logic [RESULT_W-1:0] samp(input logic [2:0] c);
		return {c, 1'b1, c, 2'b10, c} ^ 12'h9C3;
	endfunction : samp
	assign sample_i = samp(chan_o);
	task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
		n_checks++;
		if (got !== exp) begin
			$display("wrong value t=%0t got %h exp %h", $time, got, exp);
			err_count++;
		end
	endtask : chk
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge mclk_i);
		we_i    <= 1'b1;
		addr_i  <= a;
		wdata_i <= d;
		@(posedge mclk_i);
		we_i <= 1'b0;
	endtask : wr
	task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
		@(posedge mclk_i);
		re_i   <= 1'b1;
		addr_i <= a;
		@(posedge mclk_i);
		re_i <= 1'b0;
		#1;
		d = rdata_o;
	endtask : rd
	// One frame of n+1 conversions; a second command while busy must be dropped
	task automatic frame(input logic [2:0] c, input logic [3:0] n, input logic [2:0] prev,
		input bit en);
		logic [DATA_W-1:0] d;
		int                i;
		wr(REG_CMD, {20'h0, n, 5'h0, c});
		wr(REG_CMD, 32'h1);
		repeat (8) @(posedge mclk_i);
		#1;
		chk({30'h0, track_o, powered_o}, 32'h3);
		repeat (24) @(posedge mclk_i);
		#1;
		chk({30'h0, track_o, powered_o}, 32'h1);
		d = 32'h1;
		for (i = 0; i < 1000 && d[ST_BUSY_BIT] !== 1'b0; i++)
			rd(REG_STATUS, d);
		chk({31'h0, d[ST_BUSY_BIT]}, 32'h0);
		if (en) begin
			rd(REG_RESULT, d);
			chk(d, {20'h0, samp((n != 4'h0) ? c : prev)});
			rd(REG_STATUS, d);
			chk(d, {16'h0, {4'h0, n} + 8'h1, 8'h06});
			chk({29'h0, ctrl_o[CHAN_MSB:CHAN_LSB]}, {29'h0, c});
			chk({29'h0, track_o, powered_o, link.sdo_line}, 32'h1);
		end
		wr(REG_STATUS, 32'h6);
	endtask : frame
	task automatic wrap_up();
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : wrap_up
	//////////////////////////////////////////////////////////////////////
	initial begin
		mclk_i = 1'b0;
		forever #5 mclk_i = ~mclk_i;
	end
	initial begin
		#200000;
		err_count++;
		wrap_up();
	end
	initial begin
		logic [DATA_W-1:0] d;
		logic [2:0]        prev;
		int                c;
		arst_n_i  = 1'b0;
		addr_i    = '0;
		wdata_i   = '0;
		we_i      = 1'b0;
		re_i      = 1'b0;
		ce_i      = 1'b1;
		err_count = 0;
		n_checks  = 0;
		prev      = 3'h5;
		repeat (12) @(posedge mclk_i);
		arst_n_i <= 1'b1;
		frame(3'h5, 4'h0, 3'h0, 1'b0);
		rd(4'hC, d);
		chk(d, 32'h0);
		for (c = 0; c < 8; c++) begin
			frame(c[2:0], 4'h0, prev, 1'b1);
			prev = c[2:0];
		end
		frame(3'h2, 4'h2, 3'h7, 1'b1);
		repeat (600) @(posedge mclk_i);
		frame(3'h4, 4'h0, 3'h2, 1'b1);
		// Command while frozen must not start a frame
		ce_i <= 1'b0;
		wr(REG_CMD, 32'h3);
		ce_i <= 1'b1;
		rd(REG_STATUS, d);
		chk(d, 32'h00000100);
		wrap_up();
	end
endmodule : asp_tb
